// *** design/pcg_clock_gate_bank.sv ***
`timescale 1ns/10ps
// Notes on behaviour
// - Active enable one delivers peripheral clock
// - Active enable zero stops peripheral clock
// - Access to gated peripheral raises bus fault
// - Reset clears all three gate copies
// - Run, sleep, deep copies follow power mode
// - Sleep copies used only with auto gating
// - Bit 13 gates dma clock
// - Bits 4..0 gate ports e..a
// - Reserved bits read zero, ignore writes
// - Sleep copy 0x118, deep copy 0x128
// - Run copy at 0x108
module pcg_clock_gate_bank (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        sleepActive,
    input  wire logic        deepSleepActive,
    input  wire logic        periphAccess,
    input  wire logic [5:0]  periphSel,
    output logic             periphFault,
    output logic [5:0]       periphClkEn,
    output logic             irq
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [5:0]  runGate;
        logic [5:0]  sleepGate;
        logic [5:0]  deepGate;
        logic        autoGate;
        logic [5:0]  faultStatus;
        logic [5:0]  faultMask;
        logic [5:0]  clkEn;
        logic        awTaken;
        logic [11:0] awAddr;
        logic        wTaken;
        logic [31:0] wData;
        logic [3:0]  wStrb;
        logic        bValid;
        logic [1:0]  bResp;
        logic        rValid;
        logic [1:0]  rResp;
        logic [31:0] rData;
        logic        rdGate;
    } pcg_state_t;

    pcg_state_t         s_r;
    pcg_state_t         s_nxt;
    pcg_pkg::pcg_mode_t mode;
    logic [5:0]         activeGate;
    logic [5:0]         faultSet;
    logic               awHs;
    logic               wHs;
    logic               arHs;
    logic               wrFire;
    logic [31:0]        wrMask;
    logic [31:0]        wrBits;

    assign awready     = !s_r.awTaken && !s_r.bValid;
    assign wready      = !s_r.wTaken && !s_r.bValid;
    assign arready     = !s_r.rValid;
    assign awHs        = awvalid && awready;
    assign wHs         = wvalid && wready;
    assign arHs        = arvalid && arready;
    assign wrFire      = s_r.awTaken && s_r.wTaken && !s_r.bValid;
    assign wrMask      = pcg_pkg::strb_mask(s_r.wStrb);
    assign wrBits      = s_r.wData & wrMask;
    assign bvalid      = s_r.bValid;
    assign bresp       = s_r.bResp;
    assign rvalid      = s_r.rValid;
    assign rresp       = s_r.rResp;
    assign rdata       = s_r.rData;
    assign periphClkEn = s_r.clkEn;
    assign irq         = |(s_r.faultStatus & s_r.faultMask);

    // ---------------------------------------------------------------
    // Power mode and copy selection
    // ---------------------------------------------------------------
    always_comb begin
        if (deepSleepActive) begin
            mode = pcg_pkg::PCG_MODE_DEEP;
        end else if (sleepActive) begin
            mode = pcg_pkg::PCG_MODE_SLEEP;
        end else begin
            mode = pcg_pkg::PCG_MODE_RUN;
        end
    end

    always_comb begin
        activeGate = s_r.runGate;
        if (s_r.autoGate) begin
            unique case (mode)
                pcg_pkg::PCG_MODE_RUN:   activeGate = s_r.runGate;
                pcg_pkg::PCG_MODE_SLEEP: activeGate = s_r.sleepGate;
                pcg_pkg::PCG_MODE_DEEP:  activeGate = s_r.deepGate;
            endcase
        end
    end

    // Fault is judged against the enable actually driven, not the pending one
    assign faultSet    = periphAccess ? (periphSel & ~s_r.clkEn) : 6'h00;
    assign periphFault = |faultSet;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        logic [5:0] clr;
        clr   = 6'h00;
        s_nxt = s_r;

        // Registered so the gating cell sees no mid-cycle change
        s_nxt.clkEn = activeGate;

        if (awHs) begin
            s_nxt.awTaken = 1'b1;
            s_nxt.awAddr  = awaddr;
        end
        if (wHs) begin
            s_nxt.wTaken = 1'b1;
            s_nxt.wData  = wdata;
            s_nxt.wStrb  = wstrb;
        end

        if (wrFire) begin
            s_nxt.awTaken = 1'b0;
            s_nxt.wTaken  = 1'b0;
            s_nxt.bValid  = 1'b1;
            s_nxt.bResp   = pcg_pkg::RESP_OKAY;
            // Reserved bits dropped by word_to_gate
            unique case (s_r.awAddr)
                pcg_pkg::RUN_GATE_OFFS: begin
                    s_nxt.runGate = pcg_pkg::word_to_gate(
                        (pcg_pkg::gate_to_word(s_r.runGate) & ~wrMask) | wrBits);
                end
                pcg_pkg::SLEEP_GATE_OFFS: begin
                    s_nxt.sleepGate = pcg_pkg::word_to_gate(
                        (pcg_pkg::gate_to_word(s_r.sleepGate) & ~wrMask) | wrBits);
                end
                pcg_pkg::DEEP_GATE_OFFS: begin
                    s_nxt.deepGate = pcg_pkg::word_to_gate(
                        (pcg_pkg::gate_to_word(s_r.deepGate) & ~wrMask) | wrBits);
                end
                pcg_pkg::RUN_CFG_OFFS: begin
                    if (wrMask[pcg_pkg::AUTO_GATE_BIT]) begin
                        s_nxt.autoGate = s_r.wData[pcg_pkg::AUTO_GATE_BIT];
                    end
                end
                pcg_pkg::IRQ_STATUS_OFFS: begin
                    clr = pcg_pkg::word_to_gate(wrBits);
                end
                pcg_pkg::IRQ_MASK_OFFS: begin
                    s_nxt.faultMask = pcg_pkg::word_to_gate(
                        (pcg_pkg::gate_to_word(s_r.faultMask) & ~wrMask) | wrBits);
                end
                default: begin
                    s_nxt.bResp = pcg_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_r.bValid && bready) begin
            s_nxt.bValid = 1'b0;
        end

        // New fault wins over a clear in the same cycle
        s_nxt.faultStatus = (s_r.faultStatus & ~clr) | faultSet;

        if (s_r.rValid && rready) begin
            s_nxt.rValid = 1'b0;
        end
        if (arHs) begin
            s_nxt.rValid = 1'b1;
            s_nxt.rResp  = pcg_pkg::RESP_OKAY;
            s_nxt.rdGate = 1'b0;
            s_nxt.rData  = 32'h00000000;
            unique case (araddr)
                pcg_pkg::RUN_GATE_OFFS: begin
                    s_nxt.rData  = pcg_pkg::gate_to_word(s_r.runGate);
                    s_nxt.rdGate = 1'b1;
                end
                pcg_pkg::SLEEP_GATE_OFFS: begin
                    s_nxt.rData  = pcg_pkg::gate_to_word(s_r.sleepGate);
                    s_nxt.rdGate = 1'b1;
                end
                pcg_pkg::DEEP_GATE_OFFS: begin
                    s_nxt.rData  = pcg_pkg::gate_to_word(s_r.deepGate);
                    s_nxt.rdGate = 1'b1;
                end
                pcg_pkg::RUN_CFG_OFFS: begin
                    s_nxt.rData[pcg_pkg::AUTO_GATE_BIT] = s_r.autoGate;
                end
                pcg_pkg::IRQ_STATUS_OFFS: begin
                    s_nxt.rData = pcg_pkg::gate_to_word(s_r.faultStatus);
                end
                pcg_pkg::IRQ_MASK_OFFS: begin
                    s_nxt.rData = pcg_pkg::gate_to_word(s_r.faultMask);
                end
                default: begin
                    s_nxt.rResp = pcg_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence wrBoth;
        awvalid && awready && wvalid && wready;
    endsequence

    sequence respDone;
        ##2 bvalid;
    endsequence

    sequence rdRun;
        arvalid && arready && araddr == pcg_pkg::RUN_GATE_OFFS;
    endsequence

    chk_reset_clear: assert property (
        disable iff (1'b0) $rose(resetn) |->
            s_r.runGate == 6'h00 && s_r.sleepGate == 6'h00 && s_r.deepGate == 6'h00)
        else $error("Gate copies not cleared by reset");

    chk_run_applied: assert property (
        (!s_r.autoGate || (!sleepActive && !deepSleepActive)) |=>
            periphClkEn == $past(s_r.runGate))
        else $error("Run copy not applied");

    chk_sleep_applied: assert property (
        (s_r.autoGate && sleepActive && !deepSleepActive) |=>
            periphClkEn == $past(s_r.sleepGate))
        else $error("Sleep copy not applied");

    chk_deep_applied: assert property (
        (s_r.autoGate && deepSleepActive) |=> periphClkEn == $past(s_r.deepGate))
        else $error("Deep sleep copy not applied");

    chk_fault_gated: assert property (
        periphAccess && ((periphSel & ~periphClkEn) != 6'h00) |-> periphFault ##1
            ((s_r.faultStatus & $past(periphSel & ~periphClkEn)) != 6'h00))
        else $error("Gated access gave no fault");

    chk_no_fault_clocked: assert property (
        (!periphAccess || ((periphSel & ~periphClkEn) == 6'h00)) |-> !periphFault)
        else $error("Fault on clocked peripheral");

    chk_enable_source: assert property (
        !$stable(periphClkEn) |-> periphClkEn == $past(activeGate))
        else $error("Enable changed without selected copy");

    chk_reserved_zero: assert property (
        rvalid && s_r.rdGate |-> (rdata & ~pcg_pkg::GATE_WORD_MASK) == 32'h00000000)
        else $error("Reserved gate bits read nonzero");

    chk_dma_bit: assert property (
        wrFire && s_r.awAddr == pcg_pkg::RUN_GATE_OFFS && s_r.wStrb[1] |=>
            s_r.runGate[5] == $past(s_r.wData[13]) ##1 periphClkEn[5] == s_r.runGate[5]
            || s_r.autoGate)
        else $error("Dma gate bit not written");

    chk_port_bits: assert property (
        wrFire && s_r.awAddr == pcg_pkg::SLEEP_GATE_OFFS && s_r.wStrb[0] |=>
            s_r.sleepGate[4:0] == $past(s_r.wData[4:0]))
        else $error("Port gate bits not written");

    chk_deep_offset: assert property (
        wrFire && s_r.awAddr == pcg_pkg::DEEP_GATE_OFFS && s_r.wStrb[0] |=>
            s_r.deepGate[4:0] == $past(s_r.wData[4:0]) && $stable(s_r.runGate))
        else $error("Deep copy offset decode wrong");

    chk_write_resp: assert property (
        wrBoth |-> respDone)
        else $error("Write response late");

    chk_run_readback: assert property (
        rdRun |=>
            rvalid && rdata == pcg_pkg::gate_to_word($past(s_r.runGate)))
        else $error("Run copy read back wrong");

    chk_run_offset: assert property (
        wrFire && s_r.awAddr == pcg_pkg::RUN_GATE_OFFS && s_r.wStrb == 4'hf |=>
            s_r.runGate == pcg_pkg::word_to_gate($past(s_r.wData)))
        else $error("Run copy offset decode wrong");

    chk_unmapped_write: assert property (
        wrFire && s_r.awAddr != pcg_pkg::RUN_GATE_OFFS && s_r.awAddr != pcg_pkg::SLEEP_GATE_OFFS
            && s_r.awAddr != pcg_pkg::DEEP_GATE_OFFS |=>
            $stable(s_r.runGate) && $stable(s_r.sleepGate) && $stable(s_r.deepGate))
        else $error("Gate copy hit by other offset");

    chk_reset_enables: assert property (
        disable iff (1'b0) $rose(resetn) |-> periphClkEn == 6'h00 && irq == 1'b0)
        else $error("Enables not cleared by reset");

    // Status may only lose bits through an explicit clear
    chk_fault_sticky: assert property (
        !(wrFire && s_r.awAddr == pcg_pkg::IRQ_STATUS_OFFS) |=>
            (s_r.faultStatus & $past(s_r.faultStatus)) == $past(s_r.faultStatus))
        else $error("Fault status lost without clear");

    chk_fault_clear: assert property (
        wrFire && s_r.awAddr == pcg_pkg::IRQ_STATUS_OFFS && !periphAccess |=>
            (s_r.faultStatus & pcg_pkg::word_to_gate($past(wrBits))) == 6'h00)
        else $error("Fault status not cleared");

    chk_no_access_fault: assert property (
        !periphAccess |-> !periphFault)
        else $error("Fault without access");

endmodule

// *** design/pcg_pkg.sv ***
package pcg_pkg;

    // ---------------------------------------------------------------
    // Bus geometry
    // ---------------------------------------------------------------
    localparam int          ADDR_W    = 12;
    localparam int          DATA_W    = 32;
    localparam int          STRB_W    = 4;
    localparam int          NUM_GATES = 6;

    // ---------------------------------------------------------------
    // Register offsets (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [11:0] RUN_CFG_OFFS     = 12'h060;
    localparam logic [11:0] RUN_GATE_OFFS    = 12'h108;
    localparam logic [11:0] SLEEP_GATE_OFFS  = 12'h118;
    localparam logic [11:0] DEEP_GATE_OFFS   = 12'h128;
    localparam logic [11:0] IRQ_STATUS_OFFS  = 12'h150;
    localparam logic [11:0] IRQ_MASK_OFFS    = 12'h154;

    // ---------------------------------------------------------------
    // Field positions and reset values
    // ---------------------------------------------------------------
    localparam int          DMA_BIT          = 13;
    localparam int          PORT_MSB         = 4;
    localparam int          AUTO_GATE_BIT    = 27;
    localparam int          GATE_DMA_IDX     = 5;
    localparam logic [31:0] GATE_WORD_MASK   = 32'h0000201f;
    localparam logic [31:0] GATE_RESET       = 32'h00000000;
    localparam logic [31:0] CFG_RESET        = 32'h00000000;
    localparam logic [31:0] IRQ_RESET        = 32'h00000000;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    typedef enum logic [1:0] {
        PCG_MODE_RUN,
        PCG_MODE_SLEEP,
        PCG_MODE_DEEP
    } pcg_mode_t;

    // Gate vector: [5] dma, [4:0] ports e..a
    function automatic logic [31:0] gate_to_word(input logic [5:0] g);
        logic [31:0] w;
        w = 32'h00000000;
        w[DMA_BIT] = g[GATE_DMA_IDX];
        w[PORT_MSB:0] = g[PORT_MSB:0];
        return w;
    endfunction

    function automatic logic [5:0] word_to_gate(input logic [31:0] w);
        return {w[DMA_BIT], w[PORT_MSB:0]};
    endfunction

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

endpackage

// *** dv/pcg_clock_gate_bank_bench.sv ***
`timescale 1ns/10ps
module pcg_clock_gate_bank_bench;
    // ---------------------------------------------------------------
    // Stimulus and observed signals
    // ---------------------------------------------------------------
    logic        ref_clk, resetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, rvalid, arready, irq, periphFault;
    logic        sleepActive, deepSleepActive, periphAccess;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [5:0]  periphSel, periphClkEn;
    logic [31:0] seed = 32'h6b8a99e3;
    logic [31:0] gv [3];
    logic [33:0] rq [$];
    logic [1:0]  wq [$];
    int          nMismatch = 0;
    int          checksDone = 0;
    int          cyc = 0;
    // Order: config, run, sleep, deep, fault status, fault mask
    localparam logic [11:0] OFFS [6] = '{12'h060, 12'h108, 12'h118, 12'h128, 12'h150, 12'h154};
    localparam logic [1:0]  OK = pcg_pkg::RESP_OKAY;

    pcg_clock_gate_bank dut (.ref_clk(ref_clk), .resetn(resetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .sleepActive(sleepActive), .deepSleepActive(deepSleepActive),
        .periphAccess(periphAccess), .periphSel(periphSel), .periphFault(periphFault),
        .periphClkEn(periphClkEn), .irq(irq));

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] toEn(input logic [31:0] w);
        return {26'h0, w[13], w[4:0]};
    endfunction

    task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            nMismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmpResp(input logic [1:0] got, input logic [1:0] exp);
        checksDone++;
        if (got !== exp) begin
            nMismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        if (nMismatch == 0 && checksDone > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Bus master; both channels offered together, released when taken
    // ---------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic awDone, wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        wq.push_back(er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge ref_clk);
            if (!awDone && awready) begin
                awDone = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wDone && wready) begin
                wDone = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge ref_clk); while (!bvalid);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        rq.push_back({er, d});
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge ref_clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge ref_clk); while (!rvalid);
    endtask

    // Enable lags the register by one edge; sample once settled
    task automatic chkEn(input logic [31:0] exp);
        repeat (2) @(posedge ref_clk);
        #1;
        cmpWord({26'h0, periphClkEn}, exp);
        @(posedge ref_clk);
    endtask

    // ---------------------------------------------------------------
    // Result monitor and timeout
    // ---------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (resetn && rvalid && rready && rq.size() > 0) begin
            cmpWord(rdata, rq[0][31:0]);
            cmpResp(rresp, rq[0][33:32]);
            void'(rq.pop_front());
        end
        if (resetn && bvalid && bready && wq.size() > 0) begin
            cmpResp(bresp, wq.pop_front());
        end
    end

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            nMismatch++;
            complete_run();
        end
    end

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        {resetn, awvalid, wvalid, arvalid, sleepActive, deepSleepActive, periphAccess} = '0;
        {bready, rready} = 2'b11;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hf;
        periphSel = '0;
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        foreach (OFFS[i]) rd(OFFS[i], 32'h0, OK);
        chkEn(32'h0);
        for (int k = 0; k < 12; k++) begin
            v = xs();
            gv[k % 3] = v;
            wr(OFFS[1 + k % 3], v, OK);
            rd(OFFS[1 + k % 3], v & pcg_pkg::GATE_WORD_MASK, OK);
        end
        wr(12'h204, 32'hffffffff, pcg_pkg::RESP_SLVERR);
        rd(12'h204, 32'h0, pcg_pkg::RESP_SLVERR);
        // Deep case also raises sleep to see that deep wins
        for (int a = 0; a < 2; a++) begin
            if (a == 1) begin
                wr(OFFS[0], 32'hffffffff, OK);
                rd(OFFS[0], 32'h1 << pcg_pkg::AUTO_GATE_BIT, OK);
            end
            for (int m = 0; m < 3; m++) begin
                sleepActive <= (m != 0);
                deepSleepActive <= (m == 2);
                chkEn(toEn(gv[a == 1 ? m : 0]));
            end
        end
        sleepActive <= 1'b0;
        deepSleepActive <= 1'b0;
        wr(OFFS[1], 32'hffffffe5, OK);
        chkEn(32'h00000025);
        for (int p = 0; p < 6; p++) begin
            periphAccess <= 1'b1;
            periphSel <= 6'h01 << p;
            #1;
            cmpWord({31'h0, periphFault}, {31'h0, p == 1 || p == 3 || p == 4});
            @(posedge ref_clk);
        end
        periphAccess <= 1'b0;
        rd(OFFS[4], 32'h0000001a, OK);
        cmpWord({31'h0, irq}, 32'h0);
        wr(OFFS[5], 32'hffffffff, OK);
        rd(OFFS[5], pcg_pkg::GATE_WORD_MASK, OK);
        cmpWord({31'h0, irq}, 32'h1);
        wr(OFFS[4], 32'h00000008, OK);
        rd(OFFS[4], 32'h00000012, OK);
        cmpWord({31'h0, irq}, 32'h1);
        wr(OFFS[4], 32'hffffffff, OK);
        rd(OFFS[4], 32'h0, OK);
        cmpWord({31'h0, irq}, 32'h0);
        // Reset again in mid-run
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        for (int i = 0; i < 6; i++) rd(OFFS[i], 32'h0, OK);
        chkEn(32'h0);
        complete_run();
    end
endmodule
